//--- rtl/sfcr_config_regs.sv
// Configuration registers one and two of a multi-lane serial flash.
// Assumes a command decoder on core_clk that presents one register
// command at a time and samples the write latch itself; chip select
// arrives straight from the pin.
//
// Behaviour
// R1: origin bit set: protection starts low; clear: starts high.
// R2: persistence bit set makes the three protect bits volatile.
// R3: placement bit set puts 4-kB sectors high, clear puts them low.
// R4: quad default bit seeds the working quad bit at reset.
// R5: lock default bit is fixed zero and seeds the working lock bit.
// R6: working origin, persistence and placement copies mirror sources, ignore writes.
// R7: working quad bit is writable; set selects four-lane operation.
// R8: lock bit freezes protect bits and one-time bits until power cycle or device reset.
// R9: address length bit set gives 4-byte, clear 3-byte addressing.
// R10: four-wide command default selects 4-4-4 protocol when set.
// R11: line three reset enable lets data line three act as reset.
// R12: four-bit latency field sets 0 to 15 dummy cycles.
// R13: latency top bit defaults 1, may clear once, never returns to 1; the code reloads it to 1 on rst_b.
// R14: reserved bits hold zero and ignore writes.
// R15: host sets the write latch first, else writes are ignored.
// R16: volatile protect bits writable only in volatile persistence mode.
// R17: volatile bits load from persistent sources before first command.
`timescale 1ns/100ps
`default_nettype none
`include "sfcr_regs.svh"

module sfcr_config_regs (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Device reset request, reloads working bits
  input  wire logic               dev_reset_req,
  // Register command port
  input  wire sfcr_pkg::sfcr_cmd_t cmd,
  input  wire logic               write_latch,
  output logic                    cmd_ready,
  output sfcr_pkg::sfcr_rsp_t     rsp,
  // Protect bits from the persistent status register
  input  wire logic [2:0]         nv_block_protect,
  output logic [2:0]              block_protect_bits,
  // Pin level of chip select
  input  wire logic               chip_select_high,
  output logic                    line3_reset_armed,
  // Decoded configuration
  output sfcr_pkg::sfcr_cfg_t     cfg
);
  import sfcr_pkg::*;

  logic [7:0]  cfg1_nv_reg;
  logic [7:0]  cfg2_nv_reg;
  logic        quad_reg;
  logic        lock_reg;
  logic [2:0]  origin_persist_param_reg;
  logic [2:0]  bp_reg;
  logic [2:0]  cs_sync_reg;
  logic        cs_high_reg;
  sfcr_state_t state_reg;
  sfcr_rsp_t   rsp_reg;
  logic        armed_reg;
  logic        wr_ok;
  logic        one_time_ok;
  logic [7:0]  rd_mux;

  // Writes take effect only with the latch set and once loaded
  // R15: latch gates writes
  assign wr_ok       = cmd.valid & cmd.write & write_latch & (state_reg == SFCR_READY);
  // R8: lock freezes one-time bits
  assign one_time_ok = ~lock_reg;

  // Load sequence: one cycle of loading after any reset
  // R17: load before accepting
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SFCR_LOADING;
    end else if (dev_reset_req) begin
      state_reg <= SFCR_LOADING;
    end else begin
      state_reg <= SFCR_READY;
    end
  end

  // Persistent config one; one-time bits can only be programmed to 1
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_nv_reg <= `SFCR_C1_RESET;
    end else if (wr_ok && cmd.sel == `SFCR_SEL_CFG1_PERSIST) begin
      // R1: origin one-time bit
      // R2: persistence one-time bit
      // R3: placement one-time bit
      if (one_time_ok) begin
        cfg1_nv_reg[`SFCR_C1_ORIGIN]  <= cfg1_nv_reg[`SFCR_C1_ORIGIN] | cmd.wdata[`SFCR_C1_ORIGIN];
        cfg1_nv_reg[`SFCR_C1_PERSIST] <= cfg1_nv_reg[`SFCR_C1_PERSIST]
                                         | cmd.wdata[`SFCR_C1_PERSIST];
        cfg1_nv_reg[`SFCR_C1_PARAM]   <= cfg1_nv_reg[`SFCR_C1_PARAM] | cmd.wdata[`SFCR_C1_PARAM];
      end
      // R4: quad default is plain persistent
      cfg1_nv_reg[`SFCR_C1_QUAD] <= cmd.wdata[`SFCR_C1_QUAD];
      // R5: lock default stays zero
      // R14: reserved bits untouched
    end
  end

  // Persistent config two
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg2_nv_reg <= `SFCR_C2_RESET;
    end else if (wr_ok && cmd.sel == `SFCR_SEL_CFG2_PERSIST) begin
      // R9: address length
      cfg2_nv_reg[`SFCR_C2_ADDR] <= cmd.wdata[`SFCR_C2_ADDR];
      // R10: command protocol
      cfg2_nv_reg[`SFCR_C2_QPI]  <= cmd.wdata[`SFCR_C2_QPI];
      // R11: line three reset one-time
      if (one_time_ok) begin
        cfg2_nv_reg[`SFCR_C2_LINE3] <= cfg2_nv_reg[`SFCR_C2_LINE3] | cmd.wdata[`SFCR_C2_LINE3];
      end
      // R12: latency low bits free
      cfg2_nv_reg[2:0] <= cmd.wdata[2:0];
      // R13: top bit can only fall
      cfg2_nv_reg[`SFCR_C2_LAT_MSB] <= cfg2_nv_reg[`SFCR_C2_LAT_MSB]
                                       & cmd.wdata[`SFCR_C2_LAT_MSB];
    end
  end

  // Working copies of one-time bits follow their sources every cycle,
  // so a freshly programmed bit shows without waiting for a reset
  // R6: copies mirror, no writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      origin_persist_param_reg <= 3'h0;
    end else begin
      origin_persist_param_reg <= {cfg1_nv_reg[`SFCR_C1_ORIGIN],
                                   cfg1_nv_reg[`SFCR_C1_PERSIST],
                                   cfg1_nv_reg[`SFCR_C1_PARAM]};
    end
  end

  // Working quad bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      quad_reg <= 1'b0;
    end else if (state_reg == SFCR_LOADING || dev_reset_req) begin
      // R4: seed from default
      quad_reg <= cfg1_nv_reg[`SFCR_C1_QUAD];
    end else if (wr_ok && cmd.sel == `SFCR_SEL_CFG1_WORKING) begin
      // R7: writable quad bit
      quad_reg <= cmd.wdata[`SFCR_C1_QUAD];
    end
  end

  // Lock bit: only a reset can release it once set
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_reg <= 1'b0;
    end else if (state_reg == SFCR_LOADING || dev_reset_req) begin
      // R5: seed from fixed default
      lock_reg <= cfg1_nv_reg[`SFCR_C1_LOCK];
    end else if (wr_ok && cmd.sel == `SFCR_SEL_CFG1_WORKING && cmd.wdata[`SFCR_C1_LOCK]) begin
      // R8: set to lock
      lock_reg <= 1'b1;
    end
  end

  // Volatile protect bits; in persistent mode they track the status copy
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bp_reg <= `SFCR_BP_RESET;
    end else if (!origin_persist_param_reg[1] || state_reg == SFCR_LOADING) begin
      bp_reg <= nv_block_protect;
    end else if (wr_ok && cmd.sel == `SFCR_SEL_BLOCK_PROT && !lock_reg) begin
      // R16: volatile mode writes
      // R8: frozen while locked
      bp_reg <= cmd.wdata[2:0];
    end
  end

  // Chip select from the pin; a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_reg <= 3'h7;
      cs_high_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], chip_select_high};
      if (cs_sync_reg[2] == cs_sync_reg[1]) begin
        cs_high_reg <= cs_sync_reg[2];
      end
    end
  end

  // Line three acts as reset when deselected or quad is off
  // R11: reset function qualifier
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= cfg2_nv_reg[`SFCR_C2_LINE3] & (cs_high_reg | ~quad_reg);
    end
  end

  // Read selection; reserved bits come back zero
  // R14: reserved read zero
  always_comb begin
    unique case (cmd.sel)
      `SFCR_SEL_CFG1_PERSIST: rd_mux = cfg1_nv_reg;
      `SFCR_SEL_CFG1_WORKING: rd_mux = {2'h0, origin_persist_param_reg[2], 1'b0,
                                        origin_persist_param_reg[1:0], quad_reg, lock_reg};
      `SFCR_SEL_CFG2_PERSIST: rd_mux = cfg2_nv_reg;
      `SFCR_SEL_BLOCK_PROT:   rd_mux = {5'h00, bp_reg};
    endcase
  end

  // Read answer one cycle after the command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.valid <= cmd.valid & ~cmd.write & (state_reg == SFCR_READY);
      rsp_reg.rdata <= (cmd.valid && !cmd.write && state_reg == SFCR_READY) ? rd_mux : 8'h00;
    end
  end

  // Outputs straight from flops
  assign cmd_ready          = (state_reg == SFCR_READY);
  assign rsp                = rsp_reg;
  assign block_protect_bits = bp_reg;
  assign line3_reset_armed  = armed_reg;
  // R1: origin out
  // R3: placement out
  // R9: addressing out
  // R12: latency out
  assign cfg = '{quad_mode:               quad_reg,
                 lock_active:             lock_reg,
                 protect_origin_copy:     origin_persist_param_reg[2],
                 protect_persist_copy:    origin_persist_param_reg[1],
                 param_sector_place_copy: origin_persist_param_reg[0],
                 addr_length_default:     cfg2_nv_reg[`SFCR_C2_ADDR],
                 four_wide_cmd_default:   cfg2_nv_reg[`SFCR_C2_QPI],
                 line3_reset_enable:      cfg2_nv_reg[`SFCR_C2_LINE3],
                 read_latency_default:    cfg2_nv_reg[3:0]};

endmodule
`default_nettype wire

//--- rtl/sfcr_regs.svh
// Register selects, field positions and reset values of the flash
// configuration register bank. Definitions only.
`ifndef SFCR_REGS_SVH
`define SFCR_REGS_SVH

// Register selects carried by the command port
`define SFCR_SEL_CFG1_PERSIST 2'h0
`define SFCR_SEL_CFG1_WORKING 2'h1
`define SFCR_SEL_CFG2_PERSIST 2'h2
`define SFCR_SEL_BLOCK_PROT   2'h3

// Persistent config one fields
`define SFCR_C1_ORIGIN  5
`define SFCR_C1_PERSIST 3
`define SFCR_C1_PARAM   2
`define SFCR_C1_QUAD    1
`define SFCR_C1_LOCK    0

// Persistent config two fields
`define SFCR_C2_ADDR    7
`define SFCR_C2_QPI     6
`define SFCR_C2_LINE3   5
`define SFCR_C2_LAT_MSB 3

// Factory defaults
`define SFCR_C1_RESET    8'h00
`define SFCR_C2_RESET    8'h08
`define SFCR_LAT_RESET   4'h8
`define SFCR_BP_RESET    3'h0

`endif

//--- rtl/sfcr_pkg.sv
// Types shared by the configuration register bank and its users.
// Assumes the constants header is included alongside.
package sfcr_pkg;

  // One register command from the host-side decoder
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] sel;
    logic [7:0] wdata;
  } sfcr_cmd_t;

  // Register read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } sfcr_rsp_t;

  // Decoded working configuration
  typedef struct packed {
    logic       quad_mode;
    logic       lock_active;
    logic       protect_origin_copy;
    logic       protect_persist_copy;
    logic       param_sector_place_copy;
    logic       addr_length_default;
    logic       four_wide_cmd_default;
    logic       line3_reset_enable;
    logic [3:0] read_latency_default;
  } sfcr_cfg_t;

  typedef enum logic [0:0] {
    SFCR_LOADING,
    SFCR_READY
  } sfcr_state_t;

endpackage

//--- verification/sfcr_props.sv
// Port checker for the configuration register bank.
// Assumes one clock; bound to the bank at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "sfcr_regs.svh"

module sfcr_props (
  // Clock, reset, commands
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                dev_reset_req,
  input wire sfcr_pkg::sfcr_cmd_t cmd,
  input wire logic                write_latch,
  input wire logic                cmd_ready,
  // Bank outputs and the persistent protect input
  input wire sfcr_pkg::sfcr_rsp_t rsp,
  input wire logic [2:0]          nv_block_protect,
  input wire logic [2:0]          block_protect_bits,
  input wire logic                line3_reset_armed,
  input wire sfcr_pkg::sfcr_cfg_t cfg
);
  import sfcr_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_rsvd;
    cmd.valid && !cmd.write && cmd_ready && cmd.sel == `SFCR_SEL_CFG1_PERSIST
      |=> rsp.valid && rsp.rdata[7:6] == 2'h0 && !rsp.rdata[4] && !rsp.rdata[0];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("fixed bits not zero");
  property p_lat;
    !cfg.read_latency_default[3] |=> !cfg.read_latency_default[3];
  endproperty
  a_lat: assert property (p_lat) else $error("latency top bit back");
  property p_mirror;
    cmd_ready && !cfg.protect_persist_copy |=> block_protect_bits == $past(nv_block_protect);
  endproperty
  a_mirror: assert property (p_mirror) else $error("protect not mirrored");
  property p_lock;
    cfg.lock_active && cfg.protect_persist_copy && !dev_reset_req |=> $stable(block_protect_bits);
  endproperty
  a_lock: assert property (p_lock) else $error("locked protect moved");
  property p_nolatch;
    cmd.valid && cmd.write && !write_latch && !dev_reset_req
      |=> $stable({cfg.quad_mode, cfg.read_latency_default, cfg.addr_length_default});
  endproperty
  a_nolatch: assert property (p_nolatch) else $error("write without latch");
  property p_quad;
    cmd.valid && cmd.write && write_latch && cmd_ready && !dev_reset_req
      && cmd.sel == `SFCR_SEL_CFG1_WORKING |=> cfg.quad_mode == $past(cmd.wdata[1]);
  endproperty
  a_quad: assert property (p_quad) else $error("quad write lost");
  property p_arm;
    (cfg.line3_reset_enable && !cfg.quad_mode) [*2] |-> line3_reset_armed;
  endproperty
  a_arm: assert property (p_arm) else $error("line three not armed");
  property p_reload;
    $fell(dev_reset_req) |-> ##[0:1] (cmd_ready && !cfg.lock_active);
  endproperty
  a_reload: assert property (p_reload) else $error("reload incomplete");
endmodule

bind sfcr_config_regs sfcr_props i_props (.core_clk(core_clk), .rst_b(rst_b),
  .dev_reset_req(dev_reset_req), .cmd(cmd), .write_latch(write_latch),
  .cmd_ready(cmd_ready), .rsp(rsp), .nv_block_protect(nv_block_protect),
  .block_protect_bits(block_protect_bits), .line3_reset_armed(line3_reset_armed),
  .cfg(cfg));
`default_nettype wire

//--- verification/sfcr_host_model.sv
// Host command source for the configuration bank.
// Assumes its task is entered at a falling edge.
`timescale 1ns/100ps
`default_nettype none

module sfcr_host_model (
  // Clock and bank status
  input  wire logic                core_clk,
  input  wire logic                cmd_ready,
  input  wire sfcr_pkg::sfcr_rsp_t rsp,
  // Command drive
  output var sfcr_pkg::sfcr_cmd_t  cmd,
  output logic                     write_latch
);
  import sfcr_pkg::*;
  // Idle bus from time zero
  initial begin
    cmd = 12'h0FF;
    write_latch = 1'b0;
  end
  // One command, answer taken while it stands
  task op(input logic w, input logic [1:0] s, input logic [7:0] d, input logic lat,
          output logic [8:0] r);
    int n;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
      @(negedge core_clk);
    write_latch = lat;
    cmd = {1'b1, w, s, d};
    @(negedge core_clk);
    // Read answer stands for one cycle only, so take it now
    r = rsp;
    cmd = {2'b00, s, ~d}; // No stale data once released
    write_latch = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Random bench for the configuration bank against a model.
// Assumes host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import sfcr_pkg::*;
  logic       core_clk, rst_b, dev_reset_req, write_latch, cmd_ready, cs_high, armed;
  logic [2:0] nv_bp, bp_out;
  logic [8:0] r;
  sfcr_cmd_t  cmd;
  sfcr_rsp_t  rsp;
  sfcr_cfg_t  cfg;
  int         errors, num_checks, m1, m2, q, l, bp, i, k;
  sfcr_config_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .dev_reset_req(dev_reset_req),
    .cmd(cmd), .write_latch(write_latch), .cmd_ready(cmd_ready), .rsp(rsp),
    .nv_block_protect(nv_bp), .block_protect_bits(bp_out), .chip_select_high(cs_high),
    .line3_reset_armed(armed), .cfg(cfg));
  sfcr_host_model i_host (.core_clk(core_clk), .cmd_ready(cmd_ready), .rsp(rsp), .cmd(cmd),
    .write_latch(write_latch));
  // Clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Power cycle or device reset; working bits reload either way
  task reload(input logic power);
    if (power) begin
      rst_b = 1'b0;
      repeat (4) @(negedge core_clk);
      m1 = 0;
      m2 = 8'h08;
    end else
      dev_reset_req = 1'b1;
    @(negedge core_clk);
    rst_b = 1'b1;
    dev_reset_req = 1'b0;
    chk(16'(cmd_ready), 16'h0000);
    q = m1[1];
    l = 0;
    bp = nv_bp;
  endtask
  // Command, model update, then compare read data, config, protect bits
  task reg_op(input logic w, input logic [1:0] s, input logic [7:0] d, input logic lat);
    logic [7:0] e;
    i_host.op(w, s, d, lat, r);
    // Persistent mode mirrors the status copy up to the write that leaves it
    if (!m1[3])
      bp = nv_bp;
    if (w && lat)
      case (s)
        2'h0: m1 = (l ? m1 : m1 | d) & 8'h2C | d & 8'h02;
        2'h1: begin
          q = d[1];
          l = l | d[0];
        end
        2'h2: m2 = d & 8'hC7 | (l ? m2 : m2 | d) & 8'h20 | m2 & d & 8'h08;
        default: if (m1[3] && !l) bp = d[2:0];
      endcase
    e = 8'(s == 2'h0 ? m1 : s == 2'h1 ? m1 & 8'h2C | q << 1 | l : s == 2'h2 ? m2 : bp);
    if (!w)
      chk({7'h0, r}, {8'h01, e});
    chk(16'(cfg), 16'({q[0], l[0], m1[5], m1[3], m1[2], m2[7:5], m2[3:0]}));
    chk(16'(bp_out), 16'(bp));
    chk(16'(armed), 16'(m2[5] & (cs_high | !q[0])));
  endtask
  // Watchdog far past the expected run
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    errors = 0;
    num_checks = 0;
    dev_reset_req = 1'b0;
    cs_high = 1'b1;
    nv_bp = 3'h5;
    void'($urandom(32'h9E42CD90));
    for (k = 0; k < 3; k++) begin
      reload(k != 1);
      for (i = 0; i < 4; i++)
        reg_op(1'b0, 2'(i), 8'h00, 1'b0);
      for (i = 0; i < 40; i++) begin
        nv_bp = 3'($urandom);
        cs_high = 1'($urandom);
        // Let the protect mirror settle; the chip select sync settles during the command that follows
        repeat (2) @(negedge core_clk);
        reg_op(1'($urandom), 2'($urandom), 8'($urandom), $urandom % 4 != 0);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
